// [rtl/qdac_top.v]
// Serial load logic of a four-channel 8-bit converter.
// Assumes all pins but rstn and ce are asynchronous to clk; the serial clock runs at
// least four times slower than clk, and every pin level, including a
// load or clear pulse, lasts at least two clk periods.
`timescale 1ns/10ps
`include "qdac_defs.vh"

module qdac_top (
    input  wire                    clk,
    input  wire                    rstn,
    input  wire                    ce,
    input  wire                    chip_select_n,
    input  wire                    serial_clock,
    input  wire                    serial_in_shutdown_pin,
    input  wire                    pin_mid_level,
    input  wire                    clear_all_n,
    input  wire                    load_converter_n,
    output reg  [`QDAC_CODE_W-1:0] code_a,
    output reg  [`QDAC_CODE_W-1:0] code_b,
    output reg  [`QDAC_CODE_W-1:0] code_c,
    output reg  [`QDAC_CODE_W-1:0] code_d,
    output reg  [`QDAC_NCHAN-1:0]  channel_active,
    output reg                     power_down_request,
    output reg  [`QDAC_WORD_W-1:0] last_word,
    output reg                     write_strobe,
    output reg                     short_word
);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    // Chip select and the two strobes idle high, so reset them high to
    // avoid a false edge or a false clear right after reset.
    wire [5:0] pins_s;

    qdac_sync #(
        .W   (6),
        .RST (6'h2b)
    ) u_sync (
        .clk     (clk),
        .rstn    (rstn),
        .ce      (ce),
        .d_async ({chip_select_n, serial_clock, serial_in_shutdown_pin,
                   pin_mid_level, clear_all_n, load_converter_n}),
        .q       (pins_s)
    );

    wire cs_n_s  = pins_s[5];
    wire sclk_s  = pins_s[4];
    wire sdi_s   = pins_s[3];
    wire mid_s   = pins_s[2];
    wire clr_n_s = pins_s[1];
    wire ld_n_s  = pins_s[0];

    // ------------------------------------------------------------------
    // Edge detection on the synchronised serial pins
    // ------------------------------------------------------------------
    reg cs_n_d;
    reg sclk_d;

    // Delayed copies taken from the second synchroniser stage only
    always @(posedge clk) begin
        if (!rstn) begin
            cs_n_d <= 1'b1;
            sclk_d <= 1'b0;
        end else if (ce) begin
            cs_n_d <= cs_n_s;
            sclk_d <= sclk_s;
        end
    end

    wire cs_fall   = cs_n_d & ~cs_n_s;
    wire cs_rise   = ~cs_n_d & cs_n_s;
    wire sclk_rise = ~sclk_d & sclk_s;

    // Data and clock go through equal delay, so the data seen at the
    // clock edge is the data that stood at the pin at that edge.
    // A floated pin carries no data, so shifting stops in shutdown.
    wire do_shift = sclk_rise & ~cs_n_s & ~mid_s;

    // ------------------------------------------------------------------
    // Shift register
    // ------------------------------------------------------------------
    wire [`QDAC_WORD_W-1:0] word;
    wire                    word_full;

    qdac_shift u_shift (
        .clk     (clk),
        .rstn    (rstn),
        .ce      (ce),
        .restart (cs_fall),
        .shift   (do_shift),
        .bit_in  (sdi_s),
        .word    (word),
        .full    (word_full)
    );

    // ------------------------------------------------------------------
    // Word decode helpers
    // ------------------------------------------------------------------
    // Two address bits to a one-hot channel mask, A first
    function [`QDAC_NCHAN-1:0] chan_mask;
        input [1:0] sel;
        begin
            case (sel)
                2'b00:   chan_mask = 4'h1;
                2'b01:   chan_mask = 4'h2;
                2'b10:   chan_mask = 4'h4;
                2'b11:   chan_mask = 4'h8;
                default: chan_mask = 4'h0;
            endcase
        end
    endfunction

    wire [1:0] sel = {word[`QDAC_SEL_HI_BIT], word[`QDAC_SEL_LO_BIT]};
    wire [`QDAC_NCHAN-1:0] sel_mask = chan_mask(sel);
    wire all_channel_sleep_bit = word[`QDAC_ALL_BIT];
    wire channel_sleep_bit     = word[`QDAC_CHAN_BIT];
    wire [`QDAC_CODE_W-1:0] payload =
        word[`QDAC_CODE_MSB:`QDAC_CODE_LSB];

    // Fewer than twelve bits since chip select fell is not a valid word;
    // the shutdown window also blocks decode since the bits are garbage.
    wire take_word = cs_rise & word_full & ~mid_s;
    wire bad_word  = cs_rise & ~word_full & ~mid_s;

    // ------------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------------
    reg [`QDAC_CODE_W-1:0] input_reg [0:`QDAC_NCHAN-1];
    reg [`QDAC_CODE_W-1:0] conv_reg  [0:`QDAC_NCHAN-1];
    reg                    all_sleep;
    reg [`QDAC_NCHAN-1:0]  chan_sleep;
    reg [`QDAC_NCHAN-1:0]  next_chan_sleep;
    reg                    next_all_sleep;
    integer                i;
    integer                j;

    // Sleep flags after a decoded word. Active-low bits: all-sleep
    // covers every channel, channel sleep only the addressed one.
    // A word with both bits high wakes everything it speaks of.
    always @* begin
        next_all_sleep  = all_sleep;
        next_chan_sleep = chan_sleep;
        if (take_word) begin
            next_all_sleep = ~all_channel_sleep_bit;
            if (!channel_sleep_bit) begin
                next_chan_sleep = chan_sleep | sel_mask;
            end else if (all_channel_sleep_bit) begin
                next_chan_sleep = chan_sleep & ~sel_mask;
            end
        end
    end

    // Sleep flags; clear leaves them alone, reset wakes all
    always @(posedge clk) begin
        if (!rstn) begin
            all_sleep  <= 1'b0;
            chan_sleep <= 4'h0;
        end else if (ce) begin
            all_sleep  <= next_all_sleep;
            chan_sleep <= next_chan_sleep;
        end
    end

    // Input registers: clear wins over a write in the same cycle.
    // The payload is stored even when the word puts a channel to sleep.
    always @(posedge clk) begin
        if (!rstn) begin
            for (i = 0; i < `QDAC_NCHAN; i = i + 1) begin
                input_reg[i] <= `QDAC_CODE_RST;
            end
        end else if (ce) begin
            for (i = 0; i < `QDAC_NCHAN; i = i + 1) begin
                if (!clr_n_s) begin
                    input_reg[i] <= `QDAC_CODE_RST;
                end else if (take_word && sel_mask[i]) begin
                    input_reg[i] <= payload;
                end
            end
        end
    end

    // Converter registers follow their input registers while the load
    // pin is low, so a short pulse copies and a held level is
    // transparent. A sleeping channel holds its value until it wakes;
    // the new code then reaches it on the next load. The one-cycle lag
    // behind the input register is the price of fully registered logic.
    // Own loop index, so no variable is driven from two processes.
    always @(posedge clk) begin
        if (!rstn) begin
            for (j = 0; j < `QDAC_NCHAN; j = j + 1) begin
                conv_reg[j] <= `QDAC_CODE_RST;
            end
        end else if (ce) begin
            for (j = 0; j < `QDAC_NCHAN; j = j + 1) begin
                if (!clr_n_s) begin
                    conv_reg[j] <= `QDAC_CODE_RST;
                end else if (!ld_n_s && !all_sleep
                             && !chan_sleep[j]) begin
                    conv_reg[j] <= input_reg[j];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    // Converter codes, one register stage behind the converter state
    always @(posedge clk) begin
        if (!rstn) begin
            code_a <= `QDAC_CODE_RST;
            code_b <= `QDAC_CODE_RST;
            code_c <= `QDAC_CODE_RST;
            code_d <= `QDAC_CODE_RST;
        end else if (ce) begin
            code_a <= conv_reg[0];
            code_b <= conv_reg[1];
            code_c <= conv_reg[2];
            code_d <= conv_reg[3];
        end
    end

    // Hardware shutdown gates channel activity and blocks shifting and decode; it never touches
    // the registers, so leaving it restores the previous outputs.
    always @(posedge clk) begin
        if (!rstn) begin
            channel_active     <= 4'h0;
            power_down_request <= 1'b0;
        end else if (ce) begin
            power_down_request <= mid_s;
            channel_active     <= ~({4{all_sleep}} | chan_sleep
                                    | {4{mid_s}});
        end
    end

    // Word status: last accepted word, a strobe per accepted word, and
    // a flag for a chip select rise that came too early. The flag
    // drops on the next good word; a new short word wins as it sets.
    always @(posedge clk) begin
        if (!rstn) begin
            last_word    <= `QDAC_WORD_RST;
            write_strobe <= 1'b0;
            short_word   <= 1'b0;
        end else if (ce) begin
            write_strobe <= take_word;
            if (take_word) begin
                last_word  <= word;
                short_word <= 1'b0;
            end else if (bad_word) begin
                short_word <= 1'b1;
            end
        end else begin
            write_strobe <= 1'b0;
        end
    end

endmodule

// [rtl/qdac_defs.vh]
// Constants for the quad converter serial load logic.
// Assumes inclusion by bare name from every design file that needs it.
//
// Operation
// - Each transfer carries a 12-bit word, shifted in MSB first.
// - Serial data is sampled on each rising edge of the serial clock.
// - Shifting happens only while chip select is low; host holds it low.
// - On chip select rise only the last 12 bits are decoded.
// - Chip select rise loads the addressed input register or applies sleep.
// - Payload is stored even when a sleep bit is active, shown after waking.
// - Both sleep bits active together put all four channels asleep.
// - Software sleep keeps converter register contents unchanged.
// - Clear pin low zeroes every input and converter register.
// - Load pin low pulse copies the input registers of awake channels to converter registers.
// - Load pin held low makes converter registers follow input registers.
// - Data pin at mid level (floated) enters hardware shutdown.
// - Power-on reset zeroes all input and converter registers.
// - Converter data stays zero until a valid serial write completes.
// - Hardware shutdown entry or exit leaves converter registers unchanged.
`ifndef QDAC_DEFS_VH
`define QDAC_DEFS_VH

// ----------------------------------------------------------------------
// Word layout
// ----------------------------------------------------------------------
`define QDAC_WORD_W      12
`define QDAC_CODE_W      8
`define QDAC_NCHAN       4
`define QDAC_SEL_HI_BIT  11
`define QDAC_SEL_LO_BIT  10
`define QDAC_ALL_BIT     9
`define QDAC_CHAN_BIT    8
`define QDAC_CODE_MSB    7
`define QDAC_CODE_LSB    0

// ----------------------------------------------------------------------
// Reset values and counts
// ----------------------------------------------------------------------
`define QDAC_CODE_RST    8'h00
`define QDAC_WORD_RST    12'h000
`define QDAC_CNT_W       4
`define QDAC_CNT_FULL    4'hc

`endif

// [rtl/qdac_sync.v]
// Two flip-flop synchroniser for a group of pin levels.
// Assumes each bit is an independent level from outside the clock domain.
`timescale 1ns/10ps

module qdac_sync #(
    parameter W     = 1,
    parameter [W-1:0] RST = {W{1'b0}}
) (
    input  wire         clk,
    input  wire         rstn,
    input  wire         ce,
    input  wire [W-1:0] d_async,
    output reg  [W-1:0] q
);

    reg [W-1:0] meta;

    // First stage feeds only the second stage
    always @(posedge clk) begin
        if (!rstn) begin
            meta <= RST;
            q    <= RST;
        end else if (ce) begin
            meta <= d_async;
            q    <= meta;
        end
    end

endmodule

// [rtl/qdac_shift.v]
// Serial shift register with a saturating bit counter.
// Assumes shift and restart strobes are one-cycle pulses on clk.
`timescale 1ns/10ps
`include "qdac_defs.vh"

module qdac_shift (
    input  wire                    clk,
    input  wire                    rstn,
    input  wire                    ce,
    input  wire                    restart,
    input  wire                    shift,
    input  wire                    bit_in,
    output reg  [`QDAC_WORD_W-1:0] word,
    output wire                    full
);

    reg [`QDAC_CNT_W-1:0] count;

    // Older bits fall off the top, so the word always holds the last 12
    always @(posedge clk) begin
        if (!rstn) begin
            word  <= `QDAC_WORD_RST;
            count <= {`QDAC_CNT_W{1'b0}};
        end else if (ce) begin
            if (restart) begin
                count <= {`QDAC_CNT_W{1'b0}};
            end else if (shift) begin
                word <= {word[`QDAC_WORD_W-2:0], bit_in};
                if (count != `QDAC_CNT_FULL) begin
                    count <= count + 4'h1;
                end
            end
        end
    end

    // A word is complete once twelve bits arrived since chip select fell
    assign full = (count == `QDAC_CNT_FULL);

endmodule

// [test/qdac_assertions.sv]
// Concurrent checks on the quad converter load logic ports.
// Assumes it is bound to qdac_top and sees only its ports.
`timescale 1ns/10ps

module qdac_assertions (
    input logic        clk,
    input logic        rstn,
    input logic        chip_select_n,
    input logic        pin_mid_level,
    input logic        clear_all_n,
    input logic        load_converter_n,
    input logic [7:0]  code_a,
    input logic [7:0]  code_b,
    input logic [7:0]  code_c,
    input logic [7:0]  code_d,
    input logic [3:0]  channel_active,
    input logic        power_down_request,
    input logic [11:0] last_word,
    input logic        write_strobe,
    input logic        short_word
);
    // ------------------------------------------------------------------
    // Properties, all in the clk domain
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    // Load pin low long enough to pass the synchroniser
    sequence load_held;
        !load_converter_n [*4];
    endsequence
    sequence wake_a;
        write_strobe && last_word[11:8] == 4'h3;
    endsequence
    sequence wake_d;
        write_strobe && last_word[11:8] == 4'hf;
    endsequence

    reset_zero_a: assert property (
        $rose(rstn) |-> {code_a, code_b, code_c, code_d, last_word} == 44'h0)
        else $error("outputs not zero after reset");
    strobe_pulse_a: assert property (
        write_strobe |=> !write_strobe)
        else $error("write strobe longer than one cycle");
    strobe_cause_a: assert property (
        write_strobe |-> chip_select_n && $past(chip_select_n, 2))
        else $error("word accepted without chip select rise");
    short_refused_a: assert property (
        $rose(short_word) |-> !write_strobe)
        else $error("short word was accepted");
    sleep_all_a: assert property (
        write_strobe && last_word[9:8] == 2'b00 |-> ##[0:2]
        channel_active == 4'h0)
        else $error("both sleep bits left a channel awake");
    load_a_a: assert property (
        load_held ##0 wake_a |-> ##[1:2] code_a == last_word[7:0])
        else $error("channel A did not follow its write");
    load_d_a: assert property (
        load_held ##0 wake_d |-> ##[1:2] code_d == last_word[7:0])
        else $error("channel D did not follow its write");
    sleep_hold_a: assert property (
        (clear_all_n && !channel_active[3]) [*6] |=> $stable(code_d))
        else $error("sleeping channel code changed");
    hw_enter_a: assert property (
        $rose(pin_mid_level) |-> ##[2:4] power_down_request)
        else $error("floated pin did not request shutdown");
    hw_hold_a: assert property (
        (power_down_request && clear_all_n) [*6] |=>
        $stable({code_a, code_b, code_c, code_d}))
        else $error("codes changed in hardware shutdown");
    clear_zero_a: assert property (
        !clear_all_n [*6] |-> {code_a, code_b, code_c, code_d} == 32'h0)
        else $error("clear pin did not zero the codes");
    hw_no_write_a: assert property (
        power_down_request |-> !write_strobe)
        else $error("word accepted in hardware shutdown");
endmodule

bind qdac_top qdac_assertions chk (
    .clk(clk), .rstn(rstn), .chip_select_n(chip_select_n),
    .pin_mid_level(pin_mid_level), .clear_all_n(clear_all_n),
    .load_converter_n(load_converter_n), .code_a(code_a),
    .code_b(code_b), .code_c(code_c), .code_d(code_d),
    .channel_active(channel_active),
    .power_down_request(power_down_request), .last_word(last_word),
    .write_strobe(write_strobe), .short_word(short_word)
);

// [test/qdac_host.sv]
// Serial host model that drives the converter's link pins.
// Assumes its tasks are called from one process at a rising clk edge.
`timescale 1ns/10ps

module qdac_host (
    input  wire  clk,
    output logic chip_select_n,
    output logic serial_clock,
    output logic serial_in_shutdown_pin,
    output logic pin_mid_level
);
    // ------------------------------------------------------------------
    // Link idle state: clock still, chip select high
    // ------------------------------------------------------------------
    initial begin
        chip_select_n = 1'b1;
        serial_clock = 1'b0;
        serial_in_shutdown_pin = 1'b1;
        pin_mid_level = 1'b0;
    end

    // Chip select stays low for the whole frame
    task automatic open;
        chip_select_n <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    // Data set in the low half; 800 ns serial clock period
    task automatic put_bit(input logic b);
        serial_in_shutdown_pin <= b;
        repeat (4) @(posedge clk);
        serial_clock <= 1'b1;
        repeat (4) @(posedge clk);
        serial_clock <= 1'b0;
    endtask

    // Released data line shows the inverse, never a stale level
    task automatic close;
        chip_select_n <= 1'b1;
        serial_in_shutdown_pin <= ~serial_in_shutdown_pin;
        repeat (8) @(posedge clk);
    endtask

    // Three-state release seen by the comparator as mid level
    task automatic float_pin(input logic on);
        pin_mid_level <= on;
    endtask
endmodule

// [test/tb_top.sv]
// Self-checking bench for the quad converter serial load logic.
// Assumes qdac_host drives the link pins; the bench drives the rest.
`timescale 1ns/10ps

module tb_top;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic        ce = 1'b1;
    logic        clear_all_n = 1'b1;
    logic        load_converter_n = 1'b1;
    wire         chip_select_n;
    wire         serial_clock;
    wire         serial_in_shutdown_pin;
    wire         pin_mid_level;
    wire [7:0]   code_a;
    wire [7:0]   code_b;
    wire [7:0]   code_c;
    wire [7:0]   code_d;
    wire [3:0]   channel_active;
    wire         power_down_request;
    wire [11:0]  last_word;
    wire         write_strobe;
    wire         short_word;
    int          n_mismatch = 0;
    int          n_tests = 0;
    int          n_strobe = 0;
    logic [15:0] pair = 16'habc3;
    logic [7:0]  val [4] = '{8'h11, 8'h22, 8'h33, 8'h44};

    // ------------------------------------------------------------------
    // Clock, host model and device
    // ------------------------------------------------------------------
    always #50 clk = ~clk;

    // Accepted words, counted at the edge after each one-cycle strobe
    always @(posedge clk) begin
        if (write_strobe === 1'b1) begin
            n_strobe <= n_strobe + 1;
        end
    end

    qdac_host host (
        .clk(clk), .chip_select_n(chip_select_n),
        .serial_clock(serial_clock),
        .serial_in_shutdown_pin(serial_in_shutdown_pin),
        .pin_mid_level(pin_mid_level)
    );
    qdac_top uut (
        .clk(clk), .rstn(rstn), .ce(ce), .chip_select_n(chip_select_n),
        .serial_clock(serial_clock),
        .serial_in_shutdown_pin(serial_in_shutdown_pin),
        .pin_mid_level(pin_mid_level), .clear_all_n(clear_all_n),
        .load_converter_n(load_converter_n), .code_a(code_a),
        .code_b(code_b), .code_c(code_c), .code_d(code_d),
        .channel_active(channel_active),
        .power_down_request(power_down_request), .last_word(last_word),
        .write_strobe(write_strobe), .short_word(short_word)
    );

    // Four codes compared at once, A in the top byte
    task automatic check_codes(input logic [31:0] exp);
        n_tests++;
        if ({code_a, code_b, code_c, code_d} !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time,
                     {code_a, code_b, code_c, code_d}, exp);
        end
    endtask
    task automatic check_stat(input logic [11:0] got, input logic [11:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic send12(input logic [11:0] w);
        host.open();
        for (int i = 11; i >= 0; i--) host.put_bit(w[i]);
        host.close();
    endtask
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic print_verdict;
        $display("checks=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Hang guard, well beyond the roughly 1500 cycles the tests take
    initial begin
        wait_clk(20000);
        n_mismatch++;
        print_verdict();
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        wait_clk(8);
        rstn <= 1'b1;
        wait_clk(2);
        check_codes(32'h0);
        check_stat(last_word, 12'h0);
        $display("test reset done");
        for (int i = 0; i < 4; i++) send12({i[1:0], 2'b11, val[i]});
        wait_clk(8);
        check_codes(32'h0);
        check_stat(last_word, 12'hf44);
        load_converter_n <= 1'b0;
        wait_clk(3);
        load_converter_n <= 1'b1;
        wait_clk(6);
        check_codes(32'h11223344);
        $display("test load pulse done");
        load_converter_n <= 1'b0;
        send12(12'h75a);
        wait_clk(8);
        check_codes(32'h115a3344);
        host.open();
        // Two bytes, top four surplus bits must be dropped
        for (int i = 15; i >= 0; i--) host.put_bit(pair[i]);
        host.close();
        wait_clk(8);
        check_codes(32'h115ac344);
        $display("test byte pair done");
        // Stray clocks with chip select high, then an 8-bit frame
        for (int i = 0; i < 4; i++) host.put_bit(1'b1);
        host.open();
        for (int i = 0; i < 8; i++) host.put_bit(1'b0);
        host.close();
        wait_clk(8);
        check_stat({11'h0, short_word}, 12'h1);
        check_stat(last_word, 12'hbc3);
        check_stat(n_strobe[11:0], 12'h006);
        $display("test short word done");
        send12(12'h099);
        wait_clk(8);
        check_stat({8'h0, channel_active}, 12'h0);
        check_stat({11'h0, short_word}, 12'h0);
        check_codes(32'h115ac344);
        send12(12'h399);
        wait_clk(8);
        check_codes(32'h995ac344);
        send12(12'he77);
        wait_clk(8);
        check_stat({8'h0, channel_active}, 12'h7);
        check_codes(32'h995ac344);
        send12(12'hf77);
        wait_clk(8);
        check_codes(32'h995ac377);
        $display("test sleep done");
        host.float_pin(1'b1);
        wait_clk(6);
        check_stat({11'h0, power_down_request}, 12'h1);
        send12(12'h3ee);
        wait_clk(8);
        check_codes(32'h995ac377);
        check_stat(last_word, 12'hf77);
        check_stat({8'h0, channel_active}, 12'h0);
        check_stat(n_strobe[11:0], 12'h00a);
        host.float_pin(1'b0);
        wait_clk(6);
        check_stat({11'h0, power_down_request}, 12'h0);
        check_codes(32'h995ac377);
        $display("test hardware shutdown done");
        // Clock enable low: a short clear pulse must go unseen
        ce <= 1'b0;
        clear_all_n <= 1'b0;
        wait_clk(4);
        clear_all_n <= 1'b1;
        wait_clk(4);
        ce <= 1'b1;
        wait_clk(6);
        check_codes(32'h995ac377);
        $display("test clock enable done");
        clear_all_n <= 1'b0;
        wait_clk(8);
        check_codes(32'h0);
        clear_all_n <= 1'b1;
        wait_clk(6);
        check_codes(32'h0);
        $display("test clear done");
        print_verdict();
    end
endmodule
